// File: dcce_defs.vh
// Constants shared by the daisy-chain command engine and its output FIFO.
`ifndef DCCE_DEFS_VH
`define DCCE_DEFS_VH

// Command byte codes.
`define DCCE_CMD_ASSIGN 8'h57
`define DCCE_CMD_BWRITE 8'h02
`define DCCE_CMD_BREAD 8'h03
`define DCCE_UNI_SUFFIX 3'h4

// Character kinds on the byte streams.
`define DCCE_K_DATA 2'h0
`define DCCE_K_PRE 2'h1
`define DCCE_K_STOP 2'h2

// Byte positions counted from the command byte, which is position zero.
`define DCCE_IDX_ZERO_CHK 3'h1
`define DCCE_IDX_ADDR 3'h2
`define DCCE_IDX_LSB 3'h2
`define DCCE_IDX_MSB 3'h3
`define DCCE_IDX_RPEC 3'h3
`define DCCE_IDX_WPEC 3'h4
`define DCCE_IDX_RALIVE 3'h4
`define DCCE_IDX_WALIVE 3'h5
`define DCCE_IDX_MAX 3'h7

// Packet check: CRC-8 generator polynomial and seed (plain defaults).
`define DCCE_PEC_POLY 8'h07
`define DCCE_PEC_SEED 8'h00

// Reset values.
`define DCCE_UNLOCK_RST 1'b1
`define DCCE_ADDR_RST 5'h00

// Output FIFO shape.
`define DCCE_FIFO_W 10
`define DCCE_FIFO_D 4
`define DCCE_FIFO_AW 2

`endif

// File: dcce_fifo.v
// Small synchronous FIFO with a registered output stage.
`timescale 1ns/10ps
module dcce_fifo #(
  parameter W = 10,
  parameter D = 4,
  parameter AW = 2
) (
  // Clock and reset.
  input wire core_clk,
  input wire rst_n,
  // Filling side.
  input wire in_valid,
  input wire [W-1:0] in_data,
  output wire in_ready,
  // Draining side.
  output reg out_valid_r,
  output reg [W-1:0] out_data_r,
  input wire out_ready
);
  localparam [AW:0] FULL = D[AW:0];
  localparam [AW:0] ONE = {{AW{1'b0}}, 1'b1};

  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;

  // Pop moves a word into the output register whenever it is free or being taken.
  assign in_ready = (count_r != FULL);
  assign push = in_valid && in_ready;
  assign pop = (count_r != {(AW+1){1'b0}}) && (!out_valid_r || out_ready);

  // Storage has no reset; only pointers and count define content.
  always @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers, occupancy and output stage.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      out_valid_r <= 1'b0;
      out_data_r <= {W{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
        out_data_r <= mem[rd_ptr_r];
        out_valid_r <= 1'b1;
      end else if (out_ready) begin
        out_valid_r <= 1'b0;
      end
      if (push && !pop) begin
        count_r <= count_r + ONE;
      end else if (pop && !push) begin
        count_r <= count_r - ONE;
      end
    end
  end
endmodule

// File: dcce_engine.v
// Daisy-chain command engine: parses, acts on and forwards UART command packets.
`timescale 1ns/10ps
`include "dcce_defs.vh"
module dcce_engine (
  // Clock and reset.
  input wire core_clk,
  input wire rst_n,
  // Received character stream.
  input wire [7:0] rx_data,
  input wire [1:0] rx_kind,
  input wire rx_valid,
  input wire rx_manch_err,
  output reg rx_ready_r,
  // Forwarded character stream.
  output wire [7:0] tx_data,
  output wire [1:0] tx_kind,
  output wire tx_valid,
  input wire tx_ready,
  // Configuration.
  input wire cfg_single_uart,
  input wire cfg_down_path,
  input wire cfg_pec_bypass,
  input wire cfg_alive_en,
  input wire [4:0] top_addr,
  input wire [4:0] bottom_addr,
  // Software controls.
  input wire addr_unlock_wr,
  input wire pec_flag_clr,
  // Address state.
  output reg [4:0] dev_addr_r,
  output reg addr_unlock_bit_r,
  // Packet-check error flags.
  output reg pec_err_summary_flag_r,
  output reg pec_err_up_flag_r,
  output reg pec_err_down_flag_r,
  // Register map access.
  output reg [7:0] reg_sel_r,
  input wire reg_addr_ok,
  input wire [15:0] rd_data,
  output reg wr_strobe_r,
  output reg [15:0] wr_data_r
);
  // Packet modes, one-hot.
  localparam [4:0] M_IDLE = 5'h01;
  localparam [4:0] M_ASSIGN = 5'h02;
  localparam [4:0] M_WRITE = 5'h04;
  localparam [4:0] M_READ = 5'h08;
  localparam [4:0] M_OTHER = 5'h10;

  reg [4:0] mode_r;
  reg [2:0] idx_r;
  reg [7:0] crc_r;
  reg tgt_r;
  reg hdr_ok_r;
  reg ins_r;
  reg ins_pend_r;
  reg pass_r;
  reg [9:0] dl0_r;
  reg [9:0] dl1_r;
  reg [1:0] dcnt_r;
  reg [9:0] pq0_r;
  reg [9:0] pq1_r;
  reg [9:0] pq2_r;
  reg [1:0] pend_r;

  reg [4:0] cur_mode;
  reg cur_tgt;
  reg [2:0] pec_idx;
  reg [2:0] alive_idx;
  reg [7:0] byte_out;
  reg [1:0] ld_cnt;
  reg [9:0] ld0;
  reg [9:0] ld1;
  reg [9:0] ld2;
  reg store_dl;

  wire take;
  wire is_data;
  wire fifo_in_ready;
  wire [9:0] fifo_out;
  wire in_range;
  wire path_up;
  wire pec_ok;

  // One CRC-8 byte step, MSB first.
  function [7:0] pec_step;
    input [7:0] crc;
    input [7:0] din;
    integer i;
    reg [7:0] c;
    begin
      c = crc ^ din;
      for (i = 0; i < 8; i = i + 1) begin
        c = c[7] ? ((c << 1) ^ `DCCE_PEC_POLY) : (c << 1);
      end
      pec_step = c;
    end
  endfunction

  assign take = rx_valid && rx_ready_r;
  assign is_data = (rx_kind == `DCCE_K_DATA);
  assign pec_ok = (rx_data == crc_r);
  // Single-UART always reports as up path.
  assign path_up = cfg_single_uart || !cfg_down_path;
  // The slot this device fills lies between bottom and top of the chain.
  assign in_range = (dev_addr_r >= bottom_addr) && (dev_addr_r <= top_addr);

  // Decode the current byte and work out what to queue for the output.
  always @* begin
    cur_mode = mode_r;
    cur_tgt = tgt_r;
    if (idx_r == 3'h0) begin
      cur_tgt = 1'b1;
      if (rx_data == `DCCE_CMD_ASSIGN) begin
        cur_mode = M_ASSIGN;
      end else if (rx_data == `DCCE_CMD_BWRITE) begin
        cur_mode = M_WRITE;
      end else if (rx_data == `DCCE_CMD_BREAD) begin
        cur_mode = M_READ;
      end else if (rx_data[2:0] == `DCCE_UNI_SUFFIX) begin
        cur_mode = M_WRITE;
        cur_tgt = (rx_data[7:3] == dev_addr_r);
      end else begin
        cur_mode = M_OTHER;
      end
    end
    pec_idx = (cur_mode == M_READ) ? `DCCE_IDX_RPEC : `DCCE_IDX_WPEC;
    alive_idx = (cur_mode == M_READ) ? `DCCE_IDX_RALIVE : `DCCE_IDX_WALIVE;
    byte_out = rx_data;
    // Alive counter sits right after the PEC and only in alive mode.
    if (cfg_alive_en && cur_tgt && (idx_r == alive_idx) &&
        (cur_mode == M_WRITE || cur_mode == M_READ)) begin
      byte_out = rx_data + 8'h01;
    end
    if (cur_mode == M_ASSIGN && idx_r == `DCCE_IDX_ADDR && addr_unlock_bit_r && hdr_ok_r) begin
      // Up path and single-UART count up, down path counts down.
      if (path_up) begin
        byte_out = {3'h0, rx_data[4:0] + 5'h01};
      end else begin
        byte_out = {3'h0, rx_data[4:0] - 5'h01};
      end
    end
    ld_cnt = 2'h1;
    ld0 = {rx_kind, byte_out};
    ld1 = {`DCCE_K_DATA, 8'h00};
    ld2 = {`DCCE_K_DATA, 8'h00};
    store_dl = 1'b0;
    if (rx_kind == `DCCE_K_STOP && mode_r == M_READ && ins_r) begin
      if (!pass_r) begin
        // The two trailing fill bytes displaced by our data are dropped here.
        ld_cnt = 2'h1;
      end else if (dcnt_r == 2'h2) begin
        ld_cnt = 2'h3;
        ld0 = dl0_r;
        ld1 = dl1_r;
        ld2 = {rx_kind, rx_data};
      end else if (dcnt_r == 2'h1) begin
        ld_cnt = 2'h2;
        ld0 = dl0_r;
        ld1 = {rx_kind, rx_data};
      end
    end else if (is_data && cur_mode == M_READ && ins_r && idx_r >= `DCCE_IDX_LSB) begin
      // Everything after our inserted word runs two bytes late.
      store_dl = 1'b1;
      if (dcnt_r != 2'h2) begin
        ld_cnt = 2'h0;
      end else begin
        ld0 = dl0_r;
      end
    end
  end

  // Packet tracking, register actions and flags.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      mode_r <= M_IDLE;
      idx_r <= 3'h0;
      crc_r <= `DCCE_PEC_SEED;
      tgt_r <= 1'b0;
      hdr_ok_r <= 1'b0;
      ins_r <= 1'b0;
      ins_pend_r <= 1'b0;
      pass_r <= 1'b0;
      dl0_r <= 10'h000;
      dl1_r <= 10'h000;
      dcnt_r <= 2'h0;
      dev_addr_r <= `DCCE_ADDR_RST;
      addr_unlock_bit_r <= `DCCE_UNLOCK_RST;
      pec_err_summary_flag_r <= 1'b0;
      pec_err_up_flag_r <= 1'b0;
      pec_err_down_flag_r <= 1'b0;
      reg_sel_r <= 8'h00;
      wr_strobe_r <= 1'b0;
      wr_data_r <= 16'h0000;
    end else begin
      wr_strobe_r <= 1'b0;
      // Software clear comes first so that a same-cycle error still sets.
      if (pec_flag_clr) begin
        pec_err_summary_flag_r <= 1'b0;
        pec_err_up_flag_r <= 1'b0;
        pec_err_down_flag_r <= 1'b0;
      end
      if (addr_unlock_wr) begin
        addr_unlock_bit_r <= 1'b1;
      end
      if (rx_manch_err && mode_r == M_READ) begin
        pass_r <= 1'b1;
        ins_pend_r <= 1'b0;
      end
      if (ins_pend_r && pend_r == 2'h0 && !rx_manch_err) begin
        ins_pend_r <= 1'b0;
      end
      if (take && rx_kind == `DCCE_K_PRE) begin
        mode_r <= M_IDLE;
        idx_r <= 3'h0;
        crc_r <= `DCCE_PEC_SEED;
        ins_r <= 1'b0;
        pass_r <= 1'b0;
        dcnt_r <= 2'h0;
        hdr_ok_r <= 1'b0;
      end else if (take && rx_kind == `DCCE_K_STOP) begin
        mode_r <= M_IDLE;
        ins_r <= 1'b0;
        dcnt_r <= 2'h0;
      end else if (take && is_data) begin
        mode_r <= cur_mode;
        tgt_r <= cur_tgt;
        if (idx_r != `DCCE_IDX_MAX) begin
          idx_r <= idx_r + 3'h1;
        end
        if (idx_r < pec_idx) begin
          crc_r <= pec_step(crc_r, rx_data);
        end
        if (store_dl) begin
          dl0_r <= (dcnt_r == 2'h0) ? {rx_kind, byte_out} : dl1_r;
          dl1_r <= {rx_kind, byte_out};
          if (dcnt_r == 2'h0) begin
            dl0_r <= {rx_kind, byte_out};
          end
          if (dcnt_r != 2'h2) begin
            dcnt_r <= dcnt_r + 2'h1;
          end
        end
        case (cur_mode)
          M_ASSIGN: begin
            if (idx_r == `DCCE_IDX_ZERO_CHK) begin
              hdr_ok_r <= (rx_data == 8'h00);
            end
            // A locked device passes the packet on untouched.
            if (idx_r == `DCCE_IDX_ADDR && addr_unlock_bit_r && hdr_ok_r) begin
              dev_addr_r <= rx_data[4:0];
              if (!addr_unlock_wr) begin
                addr_unlock_bit_r <= 1'b0;
              end
            end
          end
          M_WRITE: begin
            if (idx_r == 3'h1) begin
              reg_sel_r <= rx_data;
            end
            if (idx_r == `DCCE_IDX_LSB) begin
              wr_data_r[7:0] <= rx_data;
            end
            if (idx_r == `DCCE_IDX_MSB) begin
              wr_data_r[15:8] <= rx_data;
            end
            if (cur_tgt && !cfg_pec_bypass && idx_r == `DCCE_IDX_WPEC) begin
              if (pec_ok) begin
                wr_strobe_r <= reg_addr_ok;
              end else begin
                pec_err_summary_flag_r <= 1'b1;
                pec_err_up_flag_r <= pec_err_up_flag_r | path_up;
                pec_err_down_flag_r <= pec_err_down_flag_r | !path_up;
              end
            end
            // Bypassed checking commits on the last byte of the packet.
            if (cur_tgt && cfg_pec_bypass &&
                idx_r == (cfg_alive_en ? `DCCE_IDX_WALIVE : `DCCE_IDX_WPEC)) begin
              wr_strobe_r <= reg_addr_ok;
            end
          end
          M_READ: begin
            if (idx_r == 3'h1) begin
              reg_sel_r <= rx_data;
              if (in_range && !pass_r && !rx_manch_err) begin
                ins_r <= 1'b1;
                ins_pend_r <= 1'b1;
              end
            end
            if (!cfg_pec_bypass && idx_r == `DCCE_IDX_RPEC && !pec_ok) begin
              pec_err_summary_flag_r <= 1'b1;
              pec_err_up_flag_r <= pec_err_up_flag_r | path_up;
              pec_err_down_flag_r <= pec_err_down_flag_r | !path_up;
            end
          end
          M_OTHER: begin
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Output queue feeding the FIFO; the receiver is held off while it drains.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      pq0_r <= 10'h000;
      pq1_r <= 10'h000;
      pq2_r <= 10'h000;
      pend_r <= 2'h0;
      rx_ready_r <= 1'b0;
    end else begin
      rx_ready_r <= !take && (pend_r == 2'h0) && !ins_pend_r;
      if (take) begin
        // Forward all but displaced read fill bytes; write packets leave as they came, except a targeted alive byte is incremented when cfg_alive_en is set.
        pq0_r <= ld0;
        pq1_r <= ld1;
        pq2_r <= ld2;
        pend_r <= ld_cnt;
      end else if (ins_pend_r && pend_r == 2'h0 && !rx_manch_err) begin
        pq0_r <= {`DCCE_K_DATA, rd_data[7:0]};
        pq1_r <= {`DCCE_K_DATA, rd_data[15:8]};
        pend_r <= 2'h2;
      end else if (pend_r != 2'h0 && fifo_in_ready) begin
        pq0_r <= pq1_r;
        pq1_r <= pq2_r;
        pend_r <= pend_r - 2'h1;
      end
    end
  end

  // Output buffer; a stalled transmitter backs up into rx_ready.
  dcce_fifo #(
    .W(`DCCE_FIFO_W),
    .D(`DCCE_FIFO_D),
    .AW(`DCCE_FIFO_AW)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(pend_r != 2'h0),
    .in_data(pq0_r),
    .in_ready(fifo_in_ready),
    .out_valid_r(tx_valid),
    .out_data_r(fifo_out),
    .out_ready(tx_ready)
  );

  assign tx_data = fifo_out[7:0];
  assign tx_kind = fifo_out[9:8];
endmodule

// File: dcce_far_model.sv
// Far-side model: a slow downstream character sink and a small register map.
`timescale 1ns/10ps
module dcce_far_model #(
  parameter [7:0] MAP_TOP = 8'h40
) (
  // Clock and reset.
  input wire core_clk,
  input wire rst_n,
  // Forwarded stream.
  input wire [7:0] tx_data,
  input wire [1:0] tx_kind,
  input wire tx_valid,
  output reg tx_ready,
  input wire stall,
  // Register map.
  input wire [7:0] reg_sel,
  output wire reg_addr_ok,
  output wire [15:0] rd_data
);
  reg [9:0] got[$];
  reg toggle_r;
  // Only the low part of the map exists, so writes above it must be dropped.
  assign reg_addr_ok = (reg_sel < MAP_TOP);
  assign rd_data = {8'hA5, reg_sel};
  // Taking every other cycle keeps the engine's buffer busy; stall holds it off entirely.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      toggle_r <= 1'b0;
      tx_ready <= 1'b0;
    end else begin
      toggle_r <= ~toggle_r;
      tx_ready <= toggle_r & ~stall;
      if (tx_valid && tx_ready) got.push_back({tx_kind, tx_data});
    end
  end
endmodule

// File: dcce_engine_chk.sv
// Concurrent checks on the ports of the command engine.
`timescale 1ns/10ps
module dcce_engine_chk (
  // Clock and reset.
  input wire core_clk,
  input wire rst_n,
  // Streams.
  input wire rx_valid,
  input wire rx_ready_r,
  input wire [7:0] tx_data,
  input wire [1:0] tx_kind,
  input wire tx_valid,
  input wire tx_ready,
  // Configuration and controls.
  input wire cfg_single_uart,
  input wire cfg_down_path,
  input wire addr_unlock_wr,
  input wire pec_flag_clr,
  // State and flags.
  input wire [4:0] dev_addr_r,
  input wire addr_unlock_bit_r,
  input wire pec_err_summary_flag_r,
  input wire pec_err_up_flag_r,
  input wire pec_err_down_flag_r,
  // Register map.
  input wire reg_addr_ok,
  input wire wr_strobe_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_STROBE_ONE: assert property (wr_strobe_r |=> !wr_strobe_r)
    else $error("write strobe longer than one cycle");
  AST_NO_BAD_REG: assert property (wr_strobe_r |-> reg_addr_ok)
    else $error("write to unimplemented register");
  AST_FLAG_STICKY: assert property (pec_err_summary_flag_r && !pec_flag_clr |=> pec_err_summary_flag_r)
    else $error("summary flag dropped without clear");
  AST_PATH_SUMMARY: assert property ($rose(pec_err_up_flag_r) || $rose(pec_err_down_flag_r) |-> pec_err_summary_flag_r)
    else $error("path flag without summary flag");
  AST_DOWN_ONLY_DUAL: assert property ($rose(pec_err_down_flag_r) |-> !$past(cfg_single_uart) && $past(cfg_down_path))
    else $error("down flag set outside dual down path");
  AST_LOCK_HOLD: assert property (!addr_unlock_bit_r && !addr_unlock_wr |=> $stable(dev_addr_r))
    else $error("address changed while locked");
  AST_ASSIGN_LOCKS: assert property (!$stable(dev_addr_r) |-> !addr_unlock_bit_r)
    else $error("address assigned without lock");
  AST_UNLOCK_WR: assert property (addr_unlock_wr |=> addr_unlock_bit_r)
    else $error("unlock write not honoured");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_kind))
    else $error("forwarded character changed before taken");
  AST_RX_GAP: assert property (rx_valid && rx_ready_r |=> !rx_ready_r)
    else $error("receive ready not dropped after take");
  // Main scenarios.
  COV_WRITE: cover property (wr_strobe_r);
  COV_PEC_ERR: cover property ($rose(pec_err_summary_flag_r));
  COV_LOCK: cover property ($fell(addr_unlock_bit_r));
endmodule
bind dcce_engine dcce_engine_chk dcce_engine_chk_inst (.core_clk(core_clk), .rst_n(rst_n),
  .rx_valid(rx_valid), .rx_ready_r(rx_ready_r), .tx_data(tx_data), .tx_kind(tx_kind),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .cfg_single_uart(cfg_single_uart),
  .cfg_down_path(cfg_down_path), .addr_unlock_wr(addr_unlock_wr), .pec_flag_clr(pec_flag_clr),
  .dev_addr_r(dev_addr_r), .addr_unlock_bit_r(addr_unlock_bit_r),
  .pec_err_summary_flag_r(pec_err_summary_flag_r), .pec_err_up_flag_r(pec_err_up_flag_r),
  .pec_err_down_flag_r(pec_err_down_flag_r), .reg_addr_ok(reg_addr_ok),
  .wr_strobe_r(wr_strobe_r));

// File: dcce_engine_tb.sv
// Self-checking testbench for the daisy-chain command engine.
`timescale 1ns/10ps
`include "dcce_defs.vh"
module dcce_engine_tb;
  reg core_clk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] rx_data = 8'h00;
  reg [1:0] rx_kind = 2'h0;
  reg rx_valid = 1'b0;
  reg cfg_single_uart = 1'b0;
  reg cfg_down_path = 1'b0;
  reg addr_unlock_wr = 1'b0;
  reg pec_flag_clr = 1'b0;
  reg stall = 1'b0;
  reg rx_manch_err = 1'b0;
  reg cfg_pec_bypass = 1'b0;
  reg cfg_alive_en = 1'b0;
  reg [4:0] top_addr = 5'h1F;
  reg [4:0] bottom_addr = 5'h00;
  reg [15:0] wr_seen = 16'h0000;
  reg [7:0] sel_seen = 8'h00;
  wire rx_ready_r, tx_valid, tx_ready, reg_addr_ok, wr_strobe_r, addr_unlock_bit_r;
  wire sum_f, up_f, dn_f;
  wire [7:0] tx_data, reg_sel_r;
  wire [1:0] tx_kind;
  wire [15:0] rd_data, wr_data_r;
  wire [4:0] dev_addr_r;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  int n_wr = 0;
  dcce_engine dcce_engine_inst (.core_clk(core_clk), .rst_n(rst_n), .rx_data(rx_data),
    .rx_kind(rx_kind), .rx_valid(rx_valid), .rx_manch_err(rx_manch_err), .rx_ready_r(rx_ready_r),
    .tx_data(tx_data), .tx_kind(tx_kind), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .cfg_single_uart(cfg_single_uart), .cfg_down_path(cfg_down_path),
    .cfg_pec_bypass(cfg_pec_bypass), .cfg_alive_en(cfg_alive_en), .top_addr(top_addr),
    .bottom_addr(bottom_addr), .addr_unlock_wr(addr_unlock_wr),
    .pec_flag_clr(pec_flag_clr), .dev_addr_r(dev_addr_r), .addr_unlock_bit_r(addr_unlock_bit_r),
    .pec_err_summary_flag_r(sum_f), .pec_err_up_flag_r(up_f), .pec_err_down_flag_r(dn_f),
    .reg_sel_r(reg_sel_r), .reg_addr_ok(reg_addr_ok), .rd_data(rd_data),
    .wr_strobe_r(wr_strobe_r), .wr_data_r(wr_data_r));
  dcce_far_model dcce_far_model_inst (.core_clk(core_clk), .rst_n(rst_n), .tx_data(tx_data),
    .tx_kind(tx_kind), .tx_valid(tx_valid), .tx_ready(tx_ready), .stall(stall),
    .reg_sel(reg_sel_r), .reg_addr_ok(reg_addr_ok), .rd_data(rd_data));
  always #20 core_clk = ~core_clk;
  // Count write strobes and cut a hang short; the tests need a few hundred cycles.
  always @(posedge core_clk) begin
    cycles++;
    // Latch what each write carried, since wr_data follows every write packet.
    if (wr_strobe_r === 1'b1) begin
      n_wr++;
      wr_seen = wr_data_r;
      sel_seen = reg_sel_r;
    end
    if (cycles == 10000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task chk(input [15:0] got, input [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // CRC-8 over the four bytes after the preamble, most significant bit first.
  function [7:0] crc(input [31:0] w);
    integer i;
    crc = 8'h00;
    for (i = 31; i >= 0; i--) crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ w[i]) ? 8'h07 : 8'h00);
  endfunction
  function [47:0] wpkt(input [7:0] cmd, input [7:0] ra, input [15:0] d, input ok);
    wpkt = {cmd, ra, d[7:0], d[15:8], crc({cmd, ra, d[7:0], d[15:8]}) ^ {7'h00, ~ok}, 8'h00};
  endfunction
  // Broadcast read: command, register, zero byte, check over those three, one fill pair.
  function [47:0] rpkt(input [7:0] ra, input ok);
    rpkt = {8'h03, ra, 8'h00, crc({8'h00, 8'h03, ra, 8'h00}) ^ {7'h00, ~ok}, 8'hC2, 8'hD3};
  endfunction
  // Held until the edge that takes it, so ready is judged half a cycle early.
  task send_c(input [1:0] k, input [7:0] d);
    @(posedge core_clk);
    rx_valid <= 1'b1;
    rx_kind <= k;
    rx_data <= d;
    @(negedge core_clk);
    while (rx_ready_r !== 1'b1) @(negedge core_clk);
    @(posedge core_clk);
    rx_valid <= 1'b0;
  endtask
  task send_pkt(input [47:0] b, input int n);
    send_c(`DCCE_K_PRE, 8'h00);
    for (int i = 0; i < n; i++) send_c(`DCCE_K_DATA, b[47 - 8 * i -: 8]);
    send_c(`DCCE_K_STOP, 8'h00);
  endtask
  task check_fwd(input [47:0] b, input int n);
    int i;
    reg [9:0] g;
    i = 0;
    while (dcce_far_model_inst.got.size() < n + 2 && i < 300) begin
      @(posedge core_clk);
      i++;
    end
    for (i = 0; i < n + 2; i++) begin
      g = dcce_far_model_inst.got.pop_front();
      if (i == 0) chk({14'h0, g[9:8]}, {14'h0, `DCCE_K_PRE});
      else if (i == n + 1) chk({14'h0, g[9:8]}, {14'h0, `DCCE_K_STOP});
      else chk({6'h0, g}, {6'h0, `DCCE_K_DATA, b[55 - 8 * i -: 8]});
    end
  endtask
  task pulse_clr;
    @(posedge core_clk) pec_flag_clr <= 1'b1;
    @(posedge core_clk) pec_flag_clr <= 1'b0;
  endtask
  task t_assign;
    cfg_single_uart <= 1'b1;
    send_pkt({8'h57, 8'h00, 8'h05, 24'h0}, 3);
    check_fwd({8'h57, 8'h00, 8'h06, 24'h0}, 3);
    chk({11'h0, dev_addr_r}, 16'h0005);
    chk({15'h0, addr_unlock_bit_r}, 16'h0000);
    send_pkt({8'h57, 8'h00, 8'h09, 24'h0}, 3);
    check_fwd({8'h57, 8'h00, 8'h09, 24'h0}, 3);
    chk({11'h0, dev_addr_r}, 16'h0005);
    @(posedge core_clk) addr_unlock_wr <= 1'b1;
    @(posedge core_clk) addr_unlock_wr <= 1'b0;
    cfg_single_uart <= 1'b0;
    cfg_down_path <= 1'b1;
    send_pkt({8'h57, 8'h00, 8'h07, 24'h0}, 3);
    check_fwd({8'h57, 8'h00, 8'h06, 24'h0}, 3);
    chk({11'h0, dev_addr_r}, 16'h0007);
    $display("test assign done");
  endtask
  // Two writes queued behind a stalled sink: the buffer must refuse, then drain in order.
  task t_write;
    int w0;
    cfg_down_path <= 1'b0;
    w0 = n_wr;
    stall <= 1'b1;
    fork
      begin
        send_pkt(wpkt(8'h02, 8'h10, 16'h1234, 1'b1), 5);
        send_pkt(wpkt(8'h02, 8'h11, 16'hABCD, 1'b0), 5);
      end
    join_none
    repeat (100) @(posedge core_clk);
    chk({15'h0, rx_ready_r}, 16'h0000);
    stall <= 1'b0;
    wait fork;
    check_fwd(wpkt(8'h02, 8'h10, 16'h1234, 1'b1), 5);
    check_fwd(wpkt(8'h02, 8'h11, 16'hABCD, 1'b0), 5);
    chk(16'(n_wr - w0), 16'h0001);
    chk(wr_seen, 16'h1234);
    chk({8'h00, sel_seen}, 16'h0010);
    chk({13'h0, sum_f, up_f, dn_f}, 16'h0006);
    repeat (10) @(posedge core_clk);
    chk({15'h0, sum_f}, 16'h0001);
    pulse_clr();
    cfg_down_path <= 1'b1;
    send_pkt(wpkt(8'h02, 8'h12, 16'h4321, 1'b0), 5);
    check_fwd(wpkt(8'h02, 8'h12, 16'h4321, 1'b0), 5);
    chk({13'h0, sum_f, up_f, dn_f}, 16'h0005);
    pulse_clr();
    cfg_down_path <= 1'b0;
    $display("test write done");
  endtask
  task t_unicast;
    int w0;
    w0 = n_wr;
    send_pkt(wpkt(8'h1C, 8'h12, 16'h5555, 1'b0), 5);
    check_fwd(wpkt(8'h1C, 8'h12, 16'h5555, 1'b0), 5);
    chk({15'h0, sum_f}, 16'h0000);
    send_pkt(wpkt(8'h3C, 8'h12, 16'h6666, 1'b1), 5);
    check_fwd(wpkt(8'h3C, 8'h12, 16'h6666, 1'b1), 5);
    chk(16'(n_wr - w0), 16'h0001);
    chk(wr_data_r, 16'h6666);
    send_pkt(wpkt(8'h02, 8'h50, 16'h7777, 1'b1), 5);
    check_fwd(wpkt(8'h02, 8'h50, 16'h7777, 1'b1), 5);
    chk(16'(n_wr - w0), 16'h0001);
    $display("test unicast done");
  endtask
  // Reads: insertion in range, none out of range, and pass-through after a line error.
  task t_read;
    reg [47:0] p;
    p = rpkt(8'h21, 1'b1);
    send_pkt(p, 6);
    check_fwd({p[47:32], 8'h21, 8'hA5, p[31:16]}, 6);
    chk({13'h0, sum_f, up_f, dn_f}, 16'h0000);
    top_addr <= 5'h06;
    p = rpkt(8'h22, 1'b1);
    send_pkt(p, 6);
    check_fwd(p, 6);
    top_addr <= 5'h1F;
    bottom_addr <= 5'h08;
    p = rpkt(8'h24, 1'b1);
    send_pkt(p, 6);
    check_fwd(p, 6);
    bottom_addr <= 5'h00;
    p = rpkt(8'h23, 1'b0);
    send_c(`DCCE_K_PRE, 8'h00);
    send_c(`DCCE_K_DATA, 8'h03);
    @(posedge core_clk) rx_manch_err <= 1'b1;
    @(posedge core_clk) rx_manch_err <= 1'b0;
    for (int i = 1; i < 6; i++) send_c(`DCCE_K_DATA, p[47 - 8 * i -: 8]);
    send_c(`DCCE_K_STOP, 8'h00);
    check_fwd(p, 6);
    chk({13'h0, sum_f, up_f, dn_f}, 16'h0006);
    pulse_clr();
    $display("test read done");
  endtask
  // Bypassed check with the alive byte: commit on the last byte despite a bad check byte.
  task t_bypass;
    int w0;
    w0 = n_wr;
    cfg_pec_bypass <= 1'b1;
    cfg_alive_en <= 1'b1;
    send_pkt(wpkt(8'h02, 8'h13, 16'h2468, 1'b0), 6);
    check_fwd(wpkt(8'h02, 8'h13, 16'h2468, 1'b0) | 48'h01, 6);
    chk(16'(n_wr - w0), 16'h0001);
    chk(wr_seen, 16'h2468);
    chk({13'h0, sum_f, up_f, dn_f}, 16'h0000);
    cfg_pec_bypass <= 1'b0;
    cfg_alive_en <= 1'b0;
    $display("test bypass done");
  endtask
  task stop_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Reset for four cycles, then run the scenarios in turn.
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_assign();
    t_write();
    t_unicast();
    t_read();
    t_bypass();
    stop_test();
  end
endmodule
